// ==== psf_pkg.sv ====
// shared constants for the pressure sensor fetch link
package psf_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned MEAS_PERIOD_NS = 2000000;
  // longest time: rounds down
  localparam int unsigned MEAS_CYCLES    = MEAS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SCL_PERIOD_NS  = 10000;
  // least time per quarter of a bus clock: rounds up
  localparam int unsigned SCL_QTR_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                           / (4 * CLK_PERIOD_NS);
  localparam logic [6:0]  TARGET_ADDR    = 7'h28;
  localparam logic [6:0]  DUMMY_ADDR     = 7'h7f;
  localparam logic        RW_READ        = 1'b1;
  localparam int unsigned PRES_W         = 14;
  localparam int unsigned TEMP_W         = 11;
  localparam int unsigned FILL_W         = 5;
  localparam logic [4:0]  FILL_BITS      = 5'h00;
  localparam logic [7:0]  FILL_BYTE      = 8'h00;
  localparam logic [1:0]  ST_NORMAL      = 2'h0;
  localparam logic [1:0]  ST_CMD         = 2'h1;
  localparam logic [1:0]  ST_STALE       = 2'h2;
  localparam logic [1:0]  ST_FAULT       = 2'h3;
  localparam int unsigned BITS_PER_FRAME = 9;
  localparam int unsigned FIFO_W         = 8;
  localparam int unsigned FIFO_D         = 16;
  typedef enum logic [1:0] {
    two_byte_fetch,
    three_byte_fetch,
    four_byte_fetch
  } psf_fetch_t;
endpackage

// ==== psf_bus_if.sv ====
// two-wire link between the bus controller and the sensor
`timescale 1ns/10ps
interface psf_bus_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-ups: any enabled driver pulls low
  assign scl = ctl_scl_oe ? ctl_scl_o : 1'b1;
  assign sda = (ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o) ? 1'b0 : 1'b1;
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl (input scl, input sda, output ctl_scl_o, output ctl_scl_oe,
               output ctl_sda_o, output ctl_sda_oe);
endinterface

// ==== psf_sensor.sv ====
// sensor end: target read logic, measurement cycle and status code
// What this block and the controller do
// - controller never sends clockless start-stop pair
// - extra start after failure restores communication
// - restart mid-transfer breaks next transfer until start
// - controller keeps data line from falling before clock
// - status code sits in top two bits
// - 00 normal, 01 command mode
// - 10 when data already fetched since measurement
// - 11 flags bridge, source or memory fault
// - fetch before first measurement returns stale code
// - fault caught in measurement, reported next fetch
// - fault code sticks until reset
// - answer only target address hex 28
// - keep sending bytes while controller acknowledges
// - byte order pressure high, low, temperature bytes
`timescale 1ns/10ps
module psf_sensor
  import psf_pkg::*;
#(
  parameter int unsigned MEAS_CYC = psf_pkg::MEAS_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  psf_bus_if.dev                         bus,
  input  wire logic [psf_pkg::PRES_W-1:0] pressure,
  input  wire logic [psf_pkg::TEMP_W-1:0] temperature,
  input  wire logic                      command_mode,
  input  wire logic                      fault_mem_signature,
  input  wire logic                      fault_bridge_open,
  input  wire logic                      fault_bridge_short,
  input  wire logic                      fault_source_loss,
  output logic [1:0]                     status_code,
  output logic                           link_broken,
  output logic                           meas_done
);
  import psf_pkg::*;

  localparam int unsigned MW = $clog2(MEAS_CYC + 1);
  localparam logic [MW-1:0] MEAS_LAST = MW'(MEAS_CYC - 1);

  typedef enum logic [2:0] {
    DS_IDLE,
    DS_ADDR,
    DS_ACK,
    DS_SEND,
    DS_MACK
  } psf_dst_t;

  typedef struct packed {
    logic              scl_p;
    logic              sda_p;
    psf_dst_t          st;
    logic [3:0]        cnt;
    logic [7:0]        sh;
    logic [2:0]        idx;
    logic              acked;
    logic              sda_oe;
    logic              broken;
    logic [MW-1:0]     mcnt;
    logic              mdone;
    logic              fresh;
    logic              fault;
    logic [PRES_W-1:0] pres;
    logic [TEMP_W-1:0] temp;
    logic [1:0]        snap_st;
    logic [PRES_W-1:0] snap_p;
    logic [TEMP_W-1:0] snap_t;
    logic [1:0]        status;
  } psf_dev_state_t;

  psf_dev_state_t q;
  psf_dev_state_t d;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic any_fault;
  logic [7:0] next_byte;

  // pins are taken as synchronous; one stage of history gives the edges
  assign scl_rise  = bus.scl & ~q.scl_p;
  assign scl_fall  = ~bus.scl & q.scl_p;
  assign bus_start = bus.scl & q.scl_p & q.sda_p & ~bus.sda;
  assign bus_stop  = bus.scl & q.scl_p & ~q.sda_p & bus.sda;
  assign any_fault = fault_mem_signature | fault_bridge_open
                   | fault_bridge_short | fault_source_loss;

  function automatic logic [1:0] status_of(input psf_dev_state_t s, input logic cmd);
    logic [1:0] r;
    r = ST_NORMAL;
    if (s.fault)
      r = ST_FAULT;
    else if (cmd)
      r = ST_CMD;
    else if (!s.fresh)
      r = ST_STALE;
    return r;
  endfunction

  // packet bytes, pressure first; bytes past the fourth are filler
  always_comb begin
    case (q.idx)
      3'h0:    next_byte = {q.snap_st, q.snap_p[13:8]};
      3'h1:    next_byte = q.snap_p[7:0];
      3'h2:    next_byte = q.snap_t[10:3];
      3'h3:    next_byte = {q.snap_t[2:0], FILL_BITS};
      default: next_byte = FILL_BYTE;
    endcase
  end

  always_comb begin
    d       = q;
    d.scl_p = bus.scl;
    d.sda_p = bus.sda;
    d.mdone = 1'b0;

    // free-running measurement cycle
    if (q.mcnt == MEAS_LAST) begin
      d.mcnt  = '0;
      d.mdone = 1'b1;
      d.pres  = pressure;
      d.temp  = temperature;
      d.fresh = 1'b1;
      // only a finished cycle sees the fault; nothing but reset clears it
      if (any_fault)
        d.fault = 1'b1;
    end else begin
      d.mcnt = q.mcnt + MW'(1);
    end
    d.status = status_of(q, command_mode);

    if (bus_start) begin
      d.sda_oe = 1'b0;
      d.cnt    = 4'h0;
      d.sh     = 8'h00;
      if (q.st != DS_IDLE) begin
        // a restart while busy poisons the next transfer
        d.broken = 1'b1;
        d.st     = DS_IDLE;
      end else if (q.broken) begin
        // this start only clears the fault; its transfer is not answered
        d.broken = 1'b0;
        d.st     = DS_IDLE;
      end else begin
        d.st = DS_ADDR;
      end
    end else if (bus_stop) begin
      if (q.st == DS_ADDR && q.cnt == 4'h0)
        d.broken = 1'b1;
      d.st     = DS_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        DS_IDLE: begin
          d.sda_oe = 1'b0;
        end
        DS_ADDR: begin
          // the data line is only sampled on rising clock edges
          if (scl_rise) begin
            d.sh  = {q.sh[6:0], bus.sda};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == 4'h8) begin
            if (q.sh == {TARGET_ADDR, RW_READ}) begin
              d.st      = DS_ACK;
              d.sda_oe  = 1'b1;
              d.snap_st = status_of(q, command_mode);
              d.snap_p  = q.pres;
              d.snap_t  = q.temp;
              d.idx     = 3'h0;
              // one fetch uses up the sample; the next fetch is stale
              d.fresh   = d.mdone;
            end else begin
              d.st = DS_IDLE;
            end
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            d.st     = DS_SEND;
            d.cnt    = 4'h0;
            d.sh     = next_byte;
            d.sda_oe = ~next_byte[7];
          end
        end
        DS_SEND: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == 4'h8) begin
              d.st     = DS_MACK;
              d.sda_oe = 1'b0;
              d.acked  = 1'b0;
              // step here so the reload on the ack fall already sees the next byte
              d.idx    = (q.idx == 3'h7) ? q.idx : q.idx + 3'h1;
            end else begin
              d.sh     = {q.sh[6:0], 1'b0};
              d.sda_oe = ~q.sh[6];
            end
          end
        end
        DS_MACK: begin
          if (scl_rise) begin
            if (bus.sda) begin
              d.st = DS_IDLE;
            end else begin
              d.acked = 1'b1;
            end
          end else if (scl_fall && q.acked) begin
            d.st  = DS_SEND;
            d.cnt = 4'h0;
          end
        end
        default: begin
          d.st     = DS_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // a new byte goes out on the fall that follows an acknowledge
    if (!bus_start && !bus_stop && q.st == DS_MACK && scl_fall && q.acked) begin
      d.sh     = next_byte;
      d.sda_oe = ~next_byte[7];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q        <= '0;
      q.scl_p  <= 1'b1;
      q.sda_p  <= 1'b1;
      q.st     <= DS_IDLE;
      q.status <= ST_STALE;
    end else begin
      q <= d;
    end
  end

  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = q.sda_oe;
  assign status_code    = q.status;
  assign link_broken    = q.broken;
  assign meas_done      = q.mdone;
endmodule

// ==== psf_controller.sv ====
// controller end: fetch engine, bus clock divider and receive fifo
`timescale 1ns/10ps
module psf_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);
  localparam int unsigned CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } psf_fifo_state_t;
  psf_fifo_state_t q;
  psf_fifo_state_t d;
  logic push;
  logic pop;
  assign in_ready  = (q.cnt != CW'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop)
      d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + AW'(1);
    d.cnt = q.cnt + CW'(push) - CW'(pop);
  end
  always_ff @(posedge clk) begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end
endmodule

module psf_controller
  import psf_pkg::*;
#(
  parameter int unsigned QTR = psf_pkg::SCL_QTR_CYCLES,
  parameter int unsigned DEPTH = psf_pkg::FIFO_D
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  psf_bus_if.ctl                         bus,
  input  wire logic                      fetch_req,
  input  wire psf_pkg::psf_fetch_t       fetch_kind,
  input  wire logic                      recover_req,
  output logic                           busy,
  output logic                           done,
  output logic                           addr_nack,
  output logic [psf_pkg::FIFO_W-1:0]     rd_data,
  output logic                           rd_valid,
  input  wire logic                      rd_ready
);
  import psf_pkg::*;

  localparam int unsigned TW = $clog2(QTR + 1);
  typedef enum logic [2:0] { CS_IDLE, CS_START, CS_BIT, CS_PUSH, CS_STOP } psf_cst_t;
  typedef struct packed {
    psf_cst_t      st;
    logic [1:0]    ph;
    logic [TW-1:0] tcnt;
    logic [3:0]    bitn;
    logic [8:0]    tx;
    logic [8:0]    rx;
    logic          addr_ph;
    logic          recov;
    logic [2:0]    left;
    logic          scl_oe;
    logic          sda_oe;
    logic          busy;
    logic          done;
    logic          nack;
  } psf_ctl_state_t;
  psf_ctl_state_t q;
  psf_ctl_state_t d;
  logic tick;
  logic f_ready;
  logic [8:0] rd_frame;

  assign tick = (q.tcnt == TW'(QTR - 1));
  // release for eight data bits, then ack every byte but the last
  assign rd_frame = {8'hff, (q.left == 3'h1)};

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (q.st == CS_IDLE || tick)
      d.tcnt = '0;
    else
      d.tcnt = q.tcnt + TW'(1);
    case (q.st)
      CS_IDLE: begin
        d.scl_oe = 1'b0;
        d.sda_oe = 1'b0;
        if (recover_req || fetch_req) begin
          d.st      = CS_START;
          d.ph      = 2'h0;
          d.busy    = 1'b1;
          d.nack    = 1'b0;
          d.addr_ph = 1'b1;
          d.recov   = recover_req;
          // recovery is a clocked dummy read nobody answers
          d.tx      = recover_req ? {DUMMY_ADDR, RW_READ, 1'b1}
                                  : {TARGET_ADDR, RW_READ, 1'b1};
          d.left    = (fetch_kind == four_byte_fetch)  ? 3'h4 :
                      (fetch_kind == three_byte_fetch) ? 3'h3 : 3'h2;
        end
      end
      CS_START: if (tick) begin
        if (q.ph == 2'h0) begin
          d.sda_oe = 1'b1;
          d.ph     = 2'h1;
        end else begin
          // never a stop straight after this start: clocks always follow
          d.scl_oe = 1'b1;
          d.ph     = 2'h0;
          d.bitn   = 4'h0;
          d.st     = CS_BIT;
        end
      end
      CS_BIT: if (tick) begin
        d.ph = q.ph + 2'h1;
        case (q.ph)
          // data moves only while the clock is low, and a low first
          // address bit leaves the line low from the start
          2'h0: d.sda_oe = ~q.tx[8];
          2'h1: d.scl_oe = 1'b0;
          2'h2: d.rx = {q.rx[7:0], bus.sda};
          default: begin
            d.scl_oe = 1'b1;
            d.tx     = {q.tx[7:0], 1'b1};
            d.bitn   = q.bitn + 4'h1;
            if (q.bitn == 4'(BITS_PER_FRAME - 1)) begin
              d.bitn = 4'h0;
              if (q.addr_ph) begin
                d.addr_ph = 1'b0;
                d.nack    = q.rx[0] & ~q.recov;
                if (q.rx[0] || q.recov)
                  d.st = CS_STOP;
                else
                  d.tx = rd_frame;
              end else begin
                d.st = CS_PUSH;
              end
            end
          end
        endcase
      end
      CS_PUSH: begin
        // a full fifo holds the clock low until the reader drains it
        if (f_ready) begin
          d.left = q.left - 3'h1;
          if (q.left == 3'h1) begin
            d.st = CS_STOP;
            d.ph = 2'h0;
          end else begin
            d.st = CS_BIT;
            d.ph = 2'h0;
            d.tx = {8'hff, (q.left == 3'h2)};
          end
        end
      end
      CS_STOP: if (tick) begin
        d.ph = q.ph + 2'h1;
        case (q.ph)
          2'h0: d.sda_oe = 1'b1;
          2'h1: d.scl_oe = 1'b0;
          2'h2: d.sda_oe = 1'b0;
          default: begin
            d.st   = CS_IDLE;
            d.busy = 1'b0;
            d.done = 1'b1;
          end
        endcase
      end
      default: d.st = CS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q    <= '0;
      q.st <= CS_IDLE;
    end else begin
      q <= d;
    end
  end

  psf_fifo #(.W(FIFO_W), .D(DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (q.st == CS_PUSH),
    .in_ready  (f_ready),
    .in_data   (q.rx[8:1]),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_scl_oe = q.scl_oe;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = q.sda_oe;
  assign busy           = q.busy;
  assign done           = q.done;
  assign addr_nack      = q.nack;
endmodule

// ==== psf_checker.sv ====
// assertions on the two-wire link between the controller and the sensor
`timescale 1ns/10ps
module psf_checker
  import psf_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q, sda_q, frm_q, pre_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  wire        st   = scl & scl_q & sda_q & ~sda;
  wire        sp   = scl & scl_q & ~sda_q & sda;
  wire        rise = scl & ~scl_q;
  // edges come from the resolved wires, so a fault shows whoever drives it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      frm_q <= 1'b0;
      pre_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      frm_q <= st | (frm_q & ~sp);
      pre_q <= st | (pre_q & ~rise);
      // saturates so long frames cannot wrap back into the address slot
      if (st) cnt_q <= 4'h0;
      else if (rise && cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
      if (rise && cnt_q < 4'h8) sh_q <= {sh_q[6:0], sda};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_bare_stop; !(pre_q && sp); endproperty
  a_bare_stop: assert property (p_bare_stop) else $error("stop without clock");
  property p_restart; st |-> !frm_q; endproperty
  a_restart: assert property (p_restart) else $error("start inside frame");
  property p_early_fall; pre_q |-> !(sda_q && !sda); endproperty
  a_early_fall: assert property (p_early_fall) else $error("data fell early");
  property p_stray; cnt_q >= 4'h8 && sh_q != {TARGET_ADDR, RW_READ} |-> !dev_sda_oe; endproperty
  a_stray: assert property (p_stray) else $error("answered foreign address");
  property p_ack;
    $fell(scl) && cnt_q == 4'h8 && sh_q == {TARGET_ADDR, RW_READ} |-> ##[1:2] dev_sda_oe;
  endproperty
  a_ack: assert property (p_ack) else $error("own address not acked");
  property p_drv_low; $changed(dev_sda_oe) |-> !scl; endproperty
  a_drv_low: assert property (p_drv_low) else $error("data moved with clock high");
  property p_hold_high; $rose(scl) |-> $stable(dev_sda_oe) [*4]; endproperty
  a_hold_high: assert property (p_hold_high) else $error("data not held");
  property p_release; !frm_q |-> !dev_sda_oe; endproperty
  a_release: assert property (p_release) else $error("line held outside frame");
endmodule

// ==== pressure_sensor_i2c_fetch_status_bench.sv ====
// bench: controller and sensor joined, plus a scripted bus on a second sensor
`timescale 1ns/10ps
module pressure_sensor_i2c_fetch_status_bench;
  import psf_pkg::*;
  localparam int QTR = 4;
  localparam int MC  = 2000;
  logic        clk, nrst, fetch_req, recover_req, rd_ready, cmd, c_scl, c_sda, s2;
  logic        busy, done, addr_nack, rd_valid, mdone, lb2, scl_d;
  logic [1:0]  stat;
  logic [3:0]  flt;
  logic [7:0]  rd_data;
  logic [13:0] pres;
  logic [10:0] temp;
  psf_fetch_t  kind;
  logic [7:0]  exp_q[$];
  logic        wbits[$];
  int          fails, checked;
  psf_bus_if bus_if();
  psf_bus_if bus2_if();
  assign bus2_if.ctl_scl_o  = 1'b0;
  assign bus2_if.ctl_sda_o  = 1'b0;
  assign bus2_if.ctl_scl_oe = c_scl;
  assign bus2_if.ctl_sda_oe = c_sda;
  psf_sensor #(.MEAS_CYC(MC)) psf_sensor_i (.clk(clk), .nrst(nrst), .bus(bus_if),
    .pressure(pres), .temperature(temp), .command_mode(cmd), .fault_mem_signature(flt[0]),
    .fault_bridge_open(flt[1]), .fault_bridge_short(flt[2]), .fault_source_loss(flt[3]),
    .status_code(stat), .link_broken(), .meas_done(mdone));
  psf_sensor #(.MEAS_CYC(MC)) psf_sensor_x_i (.clk(clk), .nrst(nrst), .bus(bus2_if),
    .pressure(pres), .temperature(temp), .command_mode(cmd), .fault_mem_signature(flt[0]),
    .fault_bridge_open(flt[1]), .fault_bridge_short(flt[2]), .fault_source_loss(flt[3]),
    .status_code(), .link_broken(lb2), .meas_done());
  psf_controller #(.QTR(QTR)) psf_controller_i (.clk(clk), .nrst(nrst), .bus(bus_if),
    .fetch_req(fetch_req), .fetch_kind(kind), .recover_req(recover_req), .busy(busy),
    .done(done), .addr_nack(addr_nack), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready));
  psf_checker psf_checker_i (.clk(clk), .nrst(nrst), .dev_sda_oe(bus_if.dev_sda_oe),
    .scl(bus_if.scl), .sda(bus_if.sda));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bus_if.scl === 1'b1 && scl_d === 1'b0) wbits.push_back(bus_if.sda);
    scl_d <= bus_if.scl;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, got, want);
    end
  endtask
  task print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task do_reset();
    nrst = 1'b0;
    step(16);
    nrst = 1'b1;
  endtask
  task wmeas();
    for (int g = 0; g < MC + 10 && mdone !== 1'b1; g++) step(1);
    chk({7'h0, mdone}, 8'h01);
    step(1);
  endtask
  task wdone();
    for (int g = 0; g < 2000 && done !== 1'b1; g++) step(1);
    chk({7'h0, done}, 8'h01);
  endtask
  task fetch(input psf_fetch_t k, input logic [1:0] st, input logic wt);
    logic [7:0] b[4];
    logic [7:0] a;
    int         n;
    n = int'(k) + 2;
    b = '{{st, pres[13:8]}, pres[7:0], temp[10:3], {temp[2:0], 5'h00}};
    for (int g = 0; g < n; g++) exp_q.push_back(b[g]);
    wbits.delete();
    kind = k;
    fetch_req = 1'b1;
    step(1);
    fetch_req = 1'b0;
    if (wt) begin
      wdone();
      for (int g = 0; g < 8; g++) a = {a[6:0], wbits[g]};
      chk(a, {TARGET_ADDR, RW_READ});
      chk({7'h0, wbits[8]}, 8'h00);
      chk({7'h0, wbits[9 * n + 8]}, 8'h01);
      // the stop condition adds one more rising clock after the last frame
      chk(8'(wbits.size()), 8'(9 * (n + 1) + 1));
    end
  endtask
  task drain();
    rd_ready = 1'b1;
    for (int g = 0; g < 3000 && exp_q.size() > 0; g++) begin
      if (rd_valid === 1'b1) chk(rd_data, exp_q.pop_front());
      step(1);
    end
    rd_ready = 1'b0;
    chk({7'h0, rd_valid}, 8'h00);
    chk(8'(exp_q.size()), 8'h00);
  endtask
  task bit2(input logic b);
    c_sda = ~b;
    step(QTR);
    c_scl = 1'b0;
    step(QTR);
    s2 = bus2_if.sda;
    step(QTR);
    c_scl = 1'b1;
    step(QTR);
  endtask
  task start2();
    c_sda = 1'b1;
    step(QTR);
    c_scl = 1'b1;
    step(QTR);
  endtask
  task stop2();
    c_sda = 1'b1;
    step(QTR);
    c_scl = 1'b0;
    step(QTR);
    c_sda = 1'b0;
    step(4 * QTR);
  endtask
  task x2(input logic [6:0] a, input logic want);
    logic [7:0] v;
    v = {a, RW_READ};
    start2();
    for (int i = 0; i < 8; i++) bit2(v[7 - i]);
    bit2(1'b1);
    chk({7'h0, ~s2}, {7'h0, want});
    // one byte then a refusal, so the sensor lets go before the stop
    if (s2 === 1'b0) repeat (9) bit2(1'b1);
    stop2();
  endtask
  task s_power_on();
    chk({6'h0, bus_if.scl, bus_if.sda}, 8'h03);
    chk({6'h0, stat}, {6'h0, ST_STALE});
    fetch(two_byte_fetch, ST_STALE, 1'b1);
    // data is invalid this early, so only the status bits are judged
    chk({6'h0, rd_data[7:6]}, {6'h0, ST_STALE});
    exp_q.delete();
    rd_ready = 1'b1;
    step(2);
    rd_ready = 1'b0;
    chk({7'h0, rd_valid}, 8'h00);
  endtask
  task s_kinds();
    for (int i = 0; i < 3; i++) begin
      pres = ~pres;
      temp = temp + 11'h123;
      wmeas();
      fetch(psf_fetch_t'(i), ST_NORMAL, 1'b1);
      fetch(psf_fetch_t'(i), ST_STALE, 1'b1);
      drain();
    end
  endtask
  task s_fill();
    repeat (4) begin
      wmeas();
      fetch(four_byte_fetch, ST_NORMAL, 1'b1);
    end
    fetch(four_byte_fetch, ST_STALE, 1'b0);
    step(400);
    chk({6'h0, busy, bus_if.scl}, 8'h02);
    drain();
    wdone();
  endtask
  task s_cmd();
    cmd = 1'b1;
    fetch(two_byte_fetch, ST_CMD, 1'b1);
    cmd = 1'b0;
    drain();
  endtask
  task s_link();
    recover_req = 1'b1;
    step(1);
    recover_req = 1'b0;
    wdone();
    // the recovery read is expected to go unanswered, so it is not flagged
    chk({7'h0, addr_nack}, 8'h00);
    x2(7'h29, 1'b0);
    x2(TARGET_ADDR, 1'b1);
    c_sda = 1'b1;
    step(2 * QTR);
    c_sda = 1'b0;
    step(2 * QTR);
    chk({7'h0, lb2}, 8'h01);
    x2(TARGET_ADDR, 1'b0);
    x2(TARGET_ADDR, 1'b1);
    start2();
    repeat (3) bit2(1'b0);
    c_sda = 1'b0;
    step(QTR);
    c_scl = 1'b0;
    step(QTR);
    start2();
    chk({7'h0, lb2}, 8'h01);
    stop2();
    x2(TARGET_ADDR, 1'b0);
    x2(TARGET_ADDR, 1'b1);
  endtask
  task s_fault();
    for (int f = 0; f < 4; f++) begin
      wmeas();
      flt[f] = 1'b1;
      fetch(two_byte_fetch, ST_NORMAL, 1'b1);
      wmeas();
      fetch(two_byte_fetch, ST_FAULT, 1'b1);
      flt = 4'h0;
      wmeas();
      fetch(two_byte_fetch, ST_FAULT, 1'b1);
      drain();
      do_reset();
      chk({6'h0, stat}, {6'h0, ST_STALE});
    end
  endtask
  initial begin
    {fetch_req, recover_req, rd_ready, cmd, c_scl, c_sda, flt} = 10'h000;
    kind = two_byte_fetch;
    pres = 14'h2a5c;
    temp = 11'h5b3;
    do_reset();
    s_power_on();
    s_kinds();
    s_fill();
    s_cmd();
    s_link();
    s_fault();
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
